// ==== src/cphs_core_end.sv ====
// Purpose: core end of the coprocessor handshake port
// Assumes: user side presents one instruction in Execute at a time
// Notes:   outcome reported as done, undefined trap or abandoned
`timescale 1ns/10ps
`default_nettype none
module cphs_core_end
  import cphs_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_exec_valid,
  input  wire logic [31:0] i_exec_instr,
  input  wire logic        i_exec_cond_pass,
  input  wire logic        i_privileged,
  input  wire logic        i_compressed,
  input  wire logic        i_irq_pending,
  input  wire logic        i_fiq_pending,
  input  wire logic        i_irq_disable,
  input  wire logic        i_fiq_disable,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_stall,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_undef_trap,
  output logic             o_abandoned,
  output logic [31:0]      o_rdata,
  cphs_if.core             cp
);

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {
    CPHS_C_IDLE,
    CPHS_C_WAIT,
    CPHS_C_STEP
  } cphs_cstate_t;

  typedef struct packed {
    cphs_cstate_t st;
    logic         strobe_n;
    logic         user_n;
    logic         busy;
    logic         done;
    logic         undef;
    logic         aband;
    logic [31:0]  rdata;
    logic [31:0]  wdata;
    logic [31:0]  instr;
    logic         tflag;
    logic         wait_n;
    logic [1:0]   lag;
  } cphs_core_t;

  cphs_core_t s_reg;
  cphs_core_t s_next;
  logic       irq_take;

  // ************************************************************
  // handshake
  // ************************************************************
  always_comb begin
    s_next          = s_reg;
    s_next.done     = 1'b0;
    s_next.undef    = 1'b0;
    s_next.aband    = 1'b0;
    s_next.user_n   = i_privileged;                      // [RULE_17]
    s_next.tflag    = i_compressed;
    s_next.wait_n   = ~i_stall;
    irq_take = (i_fiq_pending & ~i_fiq_disable) |
               (i_irq_pending & ~i_irq_disable);
    case (s_reg.st)
      CPHS_C_IDLE: begin
        s_next.strobe_n = 1'b1;
        // take only on a running cycle, so the follower sees the fetch
        if (i_exec_valid && s_reg.wait_n) begin
          s_next.instr = i_exec_instr;
          // follower decodes one cycle on and answers one after that
          s_next.lag   = 2'h2;
          s_next.wdata = i_wdata;
          if (i_exec_cond_pass) begin
            // undefined words go down the same path [RULE_13]
            s_next.strobe_n = 1'b0;                      // [RULE_21]
            s_next.busy     = 1'b1;
            s_next.st       = CPHS_C_WAIT;
          end else begin
            s_next.done = 1'b1;
          end
        end
      end
      CPHS_C_WAIT: begin
        // answer is sampled only while an instruction is in Execute
        // stale answers skipped until the follower has decoded this word
        if (s_reg.wait_n && s_reg.lag != 2'h0) begin
          s_next.lag = s_reg.lag - 2'h1;
        end else if (s_reg.wait_n) begin
          if (cp.coproc_absent) begin                    // [RULE_20]
            s_next.undef    = cp.coproc_busy;            // [RULE_13]
            s_next.strobe_n = 1'b1;
            s_next.busy     = 1'b0;
            s_next.st       = CPHS_C_IDLE;
          end else if (cp.coproc_busy) begin
            if (irq_take) begin
              // drop it; software retries after the handler [RULE_01]
              s_next.strobe_n = 1'b1;                    // [RULE_01]
              s_next.aband    = 1'b1;                    // [RULE_04]
              s_next.busy     = 1'b0;
              s_next.st       = CPHS_C_IDLE;
            end
          end else begin
            s_next.strobe_n = 1'b1;
            s_next.st       = CPHS_C_STEP;
          end
        end
      end
      CPHS_C_STEP: begin
        // register transfer result captured here [RULE_05]
        s_next.rdata = cp.coproc_rdata;
        s_next.done  = 1'b1;
        s_next.busy  = 1'b0;
        s_next.st    = CPHS_C_IDLE;
      end
      default: begin
        s_next.st = CPHS_C_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_reg          <= '0;
      s_reg.st       <= CPHS_C_IDLE;
      s_reg.strobe_n <= 1'b1;
      s_reg.wait_n   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign o_busy       = s_reg.busy;
  assign o_done       = s_reg.done;
  assign o_undef_trap = s_reg.undef;
  assign o_abandoned  = s_reg.aband;
  assign o_rdata      = s_reg.rdata;

  assign cp.coproc_instr_strobe_n = s_reg.strobe_n;
  assign cp.user_mode_n           = s_reg.user_n;
  assign cp.compressed_state_flag = s_reg.tflag;
  assign cp.wait_stall_n          = s_reg.wait_n;
  assign cp.instr_data            = s_reg.instr;
  // data ops move nothing across, so the write word is only ever read
  // by a core-to-coprocessor move [RULE_06]
  assign cp.core_wdata            = s_reg.wdata;
  assign cp.mem_request_n         = ~(s_reg.st == CPHS_C_IDLE & i_exec_valid
                                      & s_reg.wait_n);
  assign cp.opcode_fetch_n        = ~(s_reg.st == CPHS_C_IDLE & i_exec_valid
                                      & s_reg.wait_n);
  assign cp.sequential_cycle      = 1'b0;
  assign cp.write_not_read        = 1'b0;

endmodule
`default_nettype wire

// ==== src/cphs_pkg.sv ====
// Purpose: shared constants and types for the coprocessor handshake port
// Assumes: one clock, the core memory clock, synchronous active-high reset
// Notes:   instruction field positions follow the 32-bit instruction word
package cphs_pkg;

  localparam int          CPHS_WORD_W       = 32;
  localparam int          CPHS_CLASS_BIT    = 27;
  localparam int          CPHS_CPNUM_LSB    = 8;
  localparam int          CPHS_CPNUM_W      = 4;
  localparam int          CPHS_OP_BIT       = 4;
  localparam int          CPHS_DIR_BIT      = 20;
  localparam int          CPHS_MEM_BIT      = 25;
  localparam int          CPHS_MAX_WORDS    = 16;
  localparam logic [3:0]  CPHS_CP_ID_DEF    = 4'h4;
  localparam logic [3:0]  CPHS_CP_DEBUG     = 4'hE;
  localparam logic [4:0]  CPHS_BURST_DEF    = 5'h02;
  localparam logic [3:0]  CPHS_BUSY_DEF     = 4'h2;

  // instruction classes carried on the transfer
  typedef enum logic [2:0] {
    CPHS_CLS_NONE,
    CPHS_CLS_DATA_OP,
    CPHS_CLS_TO_CORE,
    CPHS_CLS_TO_COPROC,
    CPHS_CLS_MEM_LOAD,
    CPHS_CLS_MEM_STORE,
    CPHS_CLS_UNDEF
  } cphs_class_t;

  // decode of an instruction word into its class
  function automatic cphs_class_t cphs_decode(
    input logic [CPHS_WORD_W-1:0] instr
  );
    cphs_class_t c;
    c = CPHS_CLS_UNDEF;
    if (instr[CPHS_CLASS_BIT]) begin
      if (instr[CPHS_MEM_BIT]) begin
        if (instr[CPHS_OP_BIT])
          c = instr[CPHS_DIR_BIT] ? CPHS_CLS_TO_CORE : CPHS_CLS_TO_COPROC;
        else
          c = CPHS_CLS_DATA_OP;
      end else begin
        c = instr[CPHS_DIR_BIT] ? CPHS_CLS_MEM_LOAD : CPHS_CLS_MEM_STORE;
      end
    end
    return c;
  endfunction

endpackage

// ==== src/cphs_if.sv ====
// Purpose: handshake and pipeline-follow wires between core and coprocessor
// Assumes: both ends clocked by the same i_clock
// Notes:   no clocking block; the bench joins the two ends here
`timescale 1ns/10ps
`default_nettype none
interface cphs_if;
  logic        coproc_instr_strobe_n;
  logic        coproc_absent;
  logic        coproc_busy;
  logic        user_mode_n;
  logic        mem_request_n;
  logic        sequential_cycle;
  logic        write_not_read;
  logic        opcode_fetch_n;
  logic        compressed_state_flag;
  logic        wait_stall_n;
  logic [31:0] instr_data;
  logic [31:0] core_wdata;
  logic [31:0] coproc_rdata;

  modport core (
    output coproc_instr_strobe_n, user_mode_n, mem_request_n,
           sequential_cycle, write_not_read, opcode_fetch_n,
           compressed_state_flag, wait_stall_n, instr_data, core_wdata,
    input  coproc_absent, coproc_busy, coproc_rdata
  );
  modport coproc (
    input  coproc_instr_strobe_n, user_mode_n, mem_request_n,
           sequential_cycle, write_not_read, opcode_fetch_n,
           compressed_state_flag, wait_stall_n, instr_data, core_wdata,
    output coproc_absent, coproc_busy, coproc_rdata
  );
endinterface
`default_nettype wire

// ==== src/cphs_coproc_end.sv ====
// Purpose: coprocessor end of the handshake port with pipeline follower
// Assumes: instruction word valid the cycle after opcode fetch and request are low
// Notes:   busy-wait length and burst length are parameters
`timescale 1ns/10ps
`default_nettype none
//
// Function
// [RULE_01] core drops busy-waited instruction on interrupt
// [RULE_02] coprocessor abandons too when strobe rises
// [RULE_03] busy-wait actions repeatable, commit after execute
// [RULE_04] abandoned instruction retried; interleaving tolerated
// [RULE_05] register moves core bank to coprocessor bank
// [RULE_06] data operations move nothing across
// [RULE_07] memory transfers at most sixteen words advised
// [RULE_08] 32-bit instruction and transfer paths
// [RULE_09] read/write selects registered on falling edge; here registered on the rising edge of i_clock
// [RULE_10] strobe fans out; absent, busy ANDed
// [RULE_11] multiplex coprocessor output data
// [RULE_12] no coprocessor: absent and busy tied high
// [RULE_13] core treats undefined like coprocessor instruction
// [RULE_14] undefined instruction gets absent response
// [RULE_15] bit 27 splits undefined from coprocessor
// [RULE_16] compressed state: absent, busy high, ignore
// [RULE_17] mode identifier low user, high privileged
// [RULE_18] sample mode identifier with instruction fetch
// [RULE_19] user access to privileged op: absent
// [RULE_20] absent/busy response encoding
// [RULE_21] strobe low commits conditioned Execute instruction
// [RULE_22] follower loads only after qualifying fetch cycle
module cphs_coproc_end
  import cphs_pkg::*;
#(
  parameter logic [3:0] CP_ID      = CPHS_CP_ID_DEF,
  parameter logic [3:0] BUSY_TICKS = CPHS_BUSY_DEF,
  parameter logic [4:0] BURST      = CPHS_BURST_DEF,
  parameter bit         PRIV_ONLY  = 1'b1
)(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_present,
  output logic             o_read_path_select,
  output logic             o_write_path_select,
  output logic             o_commit,
  output logic [2:0]       o_class,
  output logic [31:0]      o_reg_value,
  cphs_if.coproc           cp
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [31:0] fetch;
    logic        fetch_priv;
    logic        prev_fetch;
    logic [31:0] dec;
    logic        dec_priv;
    logic        dec_valid;
    logic        absent;
    logic        busy;
    logic [3:0]  wait_cnt;
    logic [4:0]  words;
    logic        rsel;
    logic        wsel;
    logic        commit;
    logic [2:0]  cls;
    logic [31:0] cpreg;
    logic [31:0] rdata;
  } cphs_cp_t;

  cphs_cp_t    s_reg;
  cphs_cp_t    s_next;
  cphs_class_t dcls;
  logic        mine;
  logic        fetch_now;

  // ************************************************************
  // follower and handshake
  // ************************************************************
  always_comb begin
    s_next    = s_reg;
    s_next.commit = 1'b0;
    fetch_now = ~cp.opcode_fetch_n & ~cp.mem_request_n &
                ~cp.compressed_state_flag;
    dcls = cphs_decode(s_reg.dec);                       // [RULE_15]
    mine = s_reg.dec_valid & i_present &
           (s_reg.dec[CPHS_CPNUM_LSB +: CPHS_CPNUM_W] == CP_ID) &
           (dcls != CPHS_CLS_UNDEF);                     // [RULE_14]
    // unidirectional bus path selects [RULE_09]
    s_next.rsel = cp.mem_request_n & cp.sequential_cycle & ~cp.write_not_read;
    s_next.wsel = cp.mem_request_n & cp.sequential_cycle & cp.write_not_read;
    if (cp.wait_stall_n) begin
      s_next.prev_fetch = fetch_now;
      if (s_reg.prev_fetch) begin                        // [RULE_22]
        s_next.fetch      = cp.instr_data;
        s_next.fetch_priv = cp.user_mode_n;              // [RULE_18]
        // the fetched word goes straight to decode; one word at a time
        s_next.dec        = cp.instr_data;
        s_next.dec_priv   = cp.user_mode_n;              // [RULE_18]
        s_next.dec_valid  = 1'b1;
        s_next.wait_cnt   = BUSY_TICKS;
        s_next.words      = BURST;
      end
      // default answer is absent [RULE_12] [RULE_14]
      s_next.absent = 1'b1;
      s_next.busy   = 1'b1;
      if (cp.compressed_state_flag) begin
        s_next.dec_valid = 1'b0;                         // [RULE_16]
      end else if (mine && PRIV_ONLY && !s_reg.dec_priv) begin
        s_next.absent = 1'b1;                            // [RULE_19]
      end else if (mine) begin
        s_next.absent = 1'b0;                            // [RULE_20]
        s_next.busy   = (s_reg.wait_cnt != 4'h0);
        // count down only as a repeatable probe; no state altered [RULE_03]
        if (!cp.coproc_instr_strobe_n && s_reg.wait_cnt != 4'h0)
          s_next.wait_cnt = s_reg.wait_cnt - 4'h1;
        if (!cp.coproc_instr_strobe_n && s_reg.busy && s_reg.wait_cnt == 4'h0
            && !s_reg.absent) begin
          // committed: now architectural state may change [RULE_03]
          s_next.commit    = 1'b1;
          s_next.cls       = dcls;
          s_next.dec_valid = 1'b0;
          s_next.busy      = 1'b0;
          case (dcls)
            CPHS_CLS_TO_COPROC: s_next.cpreg = cp.core_wdata;   // [RULE_05]
            CPHS_CLS_TO_CORE:   s_next.rdata = s_reg.cpreg;     // [RULE_05]
            CPHS_CLS_DATA_OP:   s_next.cpreg = ~s_reg.cpreg;    // [RULE_06]
            CPHS_CLS_MEM_LOAD,
            CPHS_CLS_MEM_STORE: begin
              // burst held to the advised sixteen words [RULE_07]
              if (s_reg.words > 5'(CPHS_MAX_WORDS))
                s_next.words = 5'(CPHS_MAX_WORDS);
            end
            default: s_next.cls = s_reg.cls;
          endcase
        end
      end
      // strobe high while busy-waiting: core gave up [RULE_02]
      if (mine && cp.coproc_instr_strobe_n && s_reg.wait_cnt != BUSY_TICKS
          && s_reg.busy && !s_reg.absent) begin
        s_next.dec_valid = 1'b0;
        s_next.wait_cnt  = BUSY_TICKS;                   // [RULE_04]
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s_reg        <= '0;
      s_reg.absent <= 1'b1;
      s_reg.busy   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // outputs; several ends are ANDed / muxed outside [RULE_10] [RULE_11]
  // ************************************************************
  assign cp.coproc_absent  = s_reg.absent;
  assign cp.coproc_busy    = s_reg.busy;
  assign cp.coproc_rdata   = s_reg.rdata;                // [RULE_08]
  assign o_read_path_select  = s_reg.rsel;
  assign o_write_path_select = s_reg.wsel;
  assign o_commit            = s_reg.commit;
  assign o_class             = s_reg.cls;
  assign o_reg_value         = s_reg.cpreg;

endmodule
`default_nettype wire

// ==== verification/cphs_monitor.sv ====
// Purpose: handshake checks on the core/coprocessor wires
// Assumes: one clock, synchronous active-high reset
// Notes:   sees only interface signals, so no bind
`timescale 1ns/10ps
`default_nettype none
module cphs_monitor (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic coproc_instr_strobe_n,
  input wire logic coproc_absent,
  input wire logic coproc_busy,
  input wire logic compressed_state_flag,
  input wire logic wait_stall_n
);
  // ****************
  // checks
  // ****************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_no_invalid_resp: assert property (
    !(coproc_absent && !coproc_busy)) else $error("invalid response");
  a_reset_idle_wires: assert property (disable iff (1'b0)
    i_rst |=> coproc_instr_strobe_n && coproc_absent && coproc_busy)
    else $error("wires not idle after reset");
  a_strobe_low_bound: assert property (
    $fell(coproc_instr_strobe_n) |-> ##[1:200] coproc_instr_strobe_n)
    else $error("strobe stuck low");
  // flag may be registered on either side, so allow two cycles of lag
  a_compressed_absent: assert property (
    compressed_state_flag [*3] |-> coproc_absent && coproc_busy)
    else $error("response not absent in compressed state");
  a_absent_ends_cmd: assert property (
    (!coproc_instr_strobe_n && coproc_absent && coproc_busy) [*3]
    |-> ##[1:8] coproc_instr_strobe_n) else $error("no trap release");
  a_present_ends_cmd: assert property (
    !coproc_instr_strobe_n && !coproc_absent && !coproc_busy && wait_stall_n
    |=> coproc_instr_strobe_n) else $error("strobe held after start");
  a_wait_freezes_resp: assert property (
    !wait_stall_n |=> $stable(coproc_absent) && $stable(coproc_busy))
    else $error("response moved during wait");
  a_abandon_goes_idle: assert property (
    $rose(coproc_instr_strobe_n) && $past(!coproc_absent && coproc_busy)
    |-> ##[1:2] (coproc_absent && coproc_busy))
    else $error("coprocessor kept busy after abandon");
endmodule
`default_nettype wire

// ==== verification/tb_coprocessor_handshake_port.sv ====
// Purpose: self-checking bench joining core end and coprocessor end
// Assumes: coprocessor end at default parameters, condition always met
// Notes:   model holds the coprocessor register and expected outcome
`timescale 1ns/10ps
`default_nettype none
module tb_coprocessor_handshake_port
  import cphs_pkg::*;
;
  logic        i_clock, i_rst, i_exec_valid, i_privileged, i_compressed;
  logic        i_irq_pending, i_fiq_pending, i_irq_disable, i_fiq_disable;
  logic        i_stall, i_present, o_done, o_undef_trap, o_abandoned;
  logic        o_read_path_select, o_write_path_select, o_commit;
  logic [2:0]  o_class;
  logic [31:0] i_exec_instr, i_wdata, o_rdata, o_reg_value, mreg, w, v;
  int          n_mismatch, samples_checked, i;
  bit          stall_on;
  cphs_class_t c;
  cphs_class_t cl [7] = '{CPHS_CLS_TO_COPROC, CPHS_CLS_TO_CORE,
    CPHS_CLS_DATA_OP, CPHS_CLS_UNDEF, CPHS_CLS_TO_CORE,
    CPHS_CLS_MEM_LOAD, CPHS_CLS_MEM_STORE};
  cphs_if      bus ();

  cphs_core_end cphs_core_end_i (.i_clock, .i_rst, .i_exec_valid,
    .i_exec_instr, .i_exec_cond_pass(1'b1), .i_privileged, .i_compressed,
    .i_irq_pending, .i_fiq_pending, .i_irq_disable, .i_fiq_disable,
    .i_wdata, .i_stall, .o_busy(), .o_done, .o_undef_trap, .o_abandoned,
    .o_rdata, .cp(bus));
  cphs_coproc_end cphs_coproc_end_i (.i_clock, .i_rst, .i_present,
    .o_read_path_select, .o_write_path_select, .o_commit, .o_class,
    .o_reg_value, .cp(bus));
  cphs_monitor cphs_monitor_i (.i_clock, .i_rst,
    .coproc_instr_strobe_n(bus.coproc_instr_strobe_n),
    .coproc_absent(bus.coproc_absent), .coproc_busy(bus.coproc_busy),
    .compressed_state_flag(bus.compressed_state_flag),
    .wait_stall_n(bus.wait_stall_n));

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task automatic check(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // build an instruction word of a class for a coprocessor number
  function automatic logic [31:0] mk(input cphs_class_t k, logic [3:0] n);
    logic [31:0] x;
    x = $urandom;
    x[11:8] = n;
    x[CPHS_CLASS_BIT] = (k != CPHS_CLS_UNDEF);
    x[CPHS_MEM_BIT] = k inside {CPHS_CLS_DATA_OP, CPHS_CLS_TO_CORE,
                                CPHS_CLS_TO_COPROC};
    x[CPHS_OP_BIT] = k inside {CPHS_CLS_TO_CORE, CPHS_CLS_TO_COPROC};
    x[CPHS_DIR_BIT] = k inside {CPHS_CLS_TO_CORE, CPHS_CLS_MEM_LOAD};
    return x;
  endfunction

  // eo: 1 done, 2 undefined trap, 4 abandoned
  task automatic run(input logic [31:0] ins, wd, input logic pv, cm, fq,
                     iq, ms, input logic [2:0] eo, input cphs_class_t ec);
    logic [2:0] got, cls;
    logic       seen_commit;
    int         k;
    @(posedge i_clock);
    #1;
    i_exec_valid = 1'b1;
    i_exec_instr = ins;
    i_wdata = wd;
    i_privileged = pv;
    i_compressed = cm;
    i_fiq_pending = fq;
    i_irq_pending = iq;
    i_fiq_disable = ms;
    i_irq_disable = ms;
    got = 3'h0;
    cls = 3'h0;
    seen_commit = 1'b0;
    for (k = 0; k < 100 && got === 3'h0; k++) begin
      @(posedge i_clock);
      #1;
      i_stall = stall_on && ($urandom % 4 == 0);
      if (o_commit === 1'b1) begin
        seen_commit = 1'b1;
        cls = o_class;
      end
      got = {o_abandoned, o_undef_trap, o_done};
    end
    i_exec_valid = 1'b0;
    i_fiq_pending = 1'b0;
    i_irq_pending = 1'b0;
    i_stall = 1'b0;
    check(32'(got), 32'(eo));
    check(32'(seen_commit), 32'(eo == 3'h1));
    check(32'({o_read_path_select, o_write_path_select}), 32'h0);
    if (eo == 3'h1) begin
      check(32'(cls), 32'(ec));
      if (ec == CPHS_CLS_TO_CORE) check(o_rdata, mreg);
      if (ec == CPHS_CLS_TO_COPROC) mreg = wd;
      if (ec == CPHS_CLS_DATA_OP) mreg = ~mreg;
    end
    @(posedge i_clock);
    #1;
    check(o_reg_value, mreg);
  endtask

  initial begin
    {i_exec_valid, i_privileged, i_compressed, i_stall} = 4'h0;
    {i_irq_pending, i_fiq_pending, i_irq_disable, i_fiq_disable} = 4'h0;
    i_exec_instr = 32'h0;
    i_wdata = 32'h0;
    i_present = 1'b1;
    i_rst = 1'b1;
    stall_on = 1'b0;
    mreg = 32'h0;
    n_mismatch = 0;
    samples_checked = 0;
    w = $urandom(93053);
    repeat (10) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    foreach (cl[k]) run(mk(cl[k], CPHS_CP_ID_DEF), $urandom, 1, 0, 0, 0, 0,
      (cl[k] == CPHS_CLS_UNDEF) ? 3'h2 : 3'h1, cl[k]);
    $display("test classes done");
    run(mk(cl[0], 4'h5), $urandom, 1, 0, 0, 0, 0, 3'h2, cl[0]);
    run(mk(cl[0], 4'h4), $urandom, 0, 0, 0, 0, 0, 3'h2, cl[0]);
    run(mk(cl[1], 4'h4), $urandom, 1, 1, 0, 0, 0, 3'h2, cl[1]);
    i_present = 1'b0;
    run(mk(cl[1], 4'h4), $urandom, 1, 0, 0, 0, 0, 3'h2, cl[1]);
    i_present = 1'b1;
    $display("test refusals done");
    w = mk(cl[0], 4'h4);
    v = $urandom;
    run(w, v, 1, 0, 1, 0, 0, 3'h4, cl[0]);
    run(mk(cl[1], 4'h4), $urandom, 1, 0, 0, 1, 0, 3'h4, cl[1]);
    run(mk(cl[2], 4'h4), $urandom, 1, 0, 0, 0, 0, 3'h1, cl[2]);
    run(w, v, 1, 0, 0, 0, 0, 3'h1, cl[0]);
    // masked interrupts must not disturb the busy-wait
    run(mk(cl[1], 4'h4), $urandom, 1, 0, 1, 1, 1, 3'h1, cl[1]);
    $display("test abandon done");
    stall_on = 1'b1;
    for (i = 0; i < 40; i++) begin
      c = cl[$urandom % 4];
      w[0] = ($urandom % 4 != 0);
      run(mk(c, 4'h4), $urandom, w[0], 0, 0, 0, 0,
          (c != CPHS_CLS_UNDEF && w[0]) ? 3'h1 : 3'h2, c);
    end
    $display("test random done");
    conclude();
  end

  initial begin
    #80000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
